//--- common/sosc_pkg.sv
// Constants, timing figures, register map and types of the safety output switch control.
package sosc_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CNT_W = 32;

  // Start pulse high time window, least and longest.
  localparam int unsigned START_MIN_MS = 100;
  localparam int unsigned START_MAX_MS = 2000;
  localparam logic [CNT_W-1:0] START_MIN_CYC = CNT_W'(START_MIN_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] START_MAX_CYC = CNT_W'(START_MAX_MS * CYC_PER_MS);

  // Device start phase, during which off-state test pulses are emitted.
  localparam int unsigned START_PHASE_MS = 200;
  localparam logic [CNT_W-1:0] START_PHASE_CYC = CNT_W'(START_PHASE_MS * CYC_PER_MS);

  // Test pulse width and repetition period.
  localparam int unsigned TP_WIDTH_US = 1;
  localparam int unsigned TP_PERIOD_MS = 10;
  localparam logic [CNT_W-1:0] TP_WIDTH_CYC = CNT_W'(TP_WIDTH_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] TP_PERIOD_CYC = CNT_W'(TP_PERIOD_MS * CYC_PER_MS);

  // Register map, byte addresses on a 32-bit Avalon-MM slave.
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hc;

  // Control register fields.
  localparam int unsigned CTRL_FORCE_MANUAL = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields.
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_AUTO = 2;
  localparam int unsigned ST_IN_RANGE = 3;
  localparam int unsigned ST_CODING = 4;
  localparam int unsigned ST_EN_CH1 = 5;
  localparam int unsigned ST_EN_CH2 = 6;
  localparam int unsigned ST_OUT_ON = 7;

  // Interrupt status and mask fields.
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_ON = 0;
  localparam int unsigned IRQ_OFF = 1;
  localparam int unsigned IRQ_START_REJ = 2;
  localparam int unsigned IRQ_EN_DROP = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_STARTUP,
    ST_OPEN,
    ST_ARMED,
    ST_ACTIVE
  } sosc_state_type;

endpackage

//--- common/sosc_ctl_if.sv
// Internal carrier between the top and its test pulse and start detector modules.
interface sosc_ctl_if;
  logic test_pulse;
  logic start_cmd;
  logic start_reject;

  modport pulse (output test_pulse);
  modport det (output start_cmd, output start_reject);
  modport top (input test_pulse, input start_cmd, input start_reject);
endinterface

//--- hw/sosc_pulse_gen.sv
// Free running test pulse strobe generator.
module sosc_pulse_gen
  import sosc_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERIOD_CYC = TP_PERIOD_CYC,
  parameter logic [CNT_W-1:0] WIDTH_CYC = TP_WIDTH_CYC
)(
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  sosc_ctl_if.pulse ctl // Test pulse strobe out.
);

  logic [CNT_W-1:0] cnt_r;
  logic pulse_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (cnt_r >= PERIOD_CYC - CNT_W'(1))
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CNT_W'(1);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pulse_r <= 1'b0;
    else
      pulse_r <= (cnt_r < WIDTH_CYC);
  end

  assign ctl.test_pulse = pulse_r;

endmodule

//--- hw/sosc_start_det.sv
// Monitored start detector: validates the high time of the start input.
module sosc_start_det
  import sosc_pkg::*;
#(
  parameter logic [CNT_W-1:0] MIN_CYC = START_MIN_CYC,
  parameter logic [CNT_W-1:0] MAX_CYC = START_MAX_CYC
)(
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic start_in, // Start input level.
  sosc_ctl_if.det ctl // Start command and reject pulses.
);

  logic prev_r;
  logic [CNT_W-1:0] high_cnt_r;
  logic cmd_r;
  logic rej_r;
  logic fall;
  logic in_window;

  assign fall = prev_r & ~start_in;
  assign in_window = (high_cnt_r >= MIN_CYC) && (high_cnt_r <= MAX_CYC);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= 1'b0;
    else
      prev_r <= start_in;
  end

  // The count saturates one above the limit so an overlong press stays invalid.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      high_cnt_r <= '0;
    else if (!start_in)
      high_cnt_r <= '0;
    else if (high_cnt_r <= MAX_CYC)
      high_cnt_r <= high_cnt_r + CNT_W'(1);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r <= 1'b0;
      rej_r <= 1'b0;
    end
    else
    begin
      cmd_r <= fall & in_window;
      rej_r <= fall & ~in_window;
    end
  end

  assign ctl.start_cmd = cmd_r;
  assign ctl.start_reject = rej_r;

endmodule

//--- hw/sosc_top.sv
// Safety output switch control: state machine, outputs, test pulses and register slave.

// Function
// - Power and data exchange with the actuator start on reaching range, before any coding check.
// - After valid coding, outputs turn on only when the startup mode permits it.
// - Leaving the response area switches both safety outputs off.
// - Test pulses appear on the outputs while on, and while off during the start phase.
// - The diagnostic output turns on as soon as the actuator leaves the response area.
// - Outputs on and diagnostic off only with range, valid coding and start or autostart.
// - In range and coded but without start, outputs stay off and diagnostic on.
// - With the guard open, outputs stay off and diagnostic on.
// - Two safety outputs, one per redundant channel.
// - Two enable inputs, one per channel; dropping either one switches both outputs off.
// - The diagnostic output is information only and takes no part in the shutdown path.
// - Autostart is chosen when the first output's pulse pattern is seen at the start input; here only while CTRL_FORCE_MANUAL is clear.
// - A manual start is a falling edge after a high time of 100 ms to 2 s.
module sosc_top
  import sosc_pkg::*;
#(
  parameter logic [CNT_W-1:0] START_MIN_CYCLES = START_MIN_CYC,
  parameter logic [CNT_W-1:0] START_MAX_CYCLES = START_MAX_CYC,
  parameter logic [CNT_W-1:0] START_PHASE_CYCLES = START_PHASE_CYC,
  parameter logic [CNT_W-1:0] TP_PERIOD_CYCLES = TP_PERIOD_CYC,
  parameter logic [CNT_W-1:0] TP_WIDTH_CYCLES = TP_WIDTH_CYC
)(
  input wire logic clock, // System clock, 100 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic actuator_in_range, // Actuator within the response area.
  input wire logic coding_valid, // Actuator coding recognised as permissible.
  input wire logic start_in, // Start/reset input level.
  input wire logic chain_enable_in_ch1, // Enable input, channel 1.
  input wire logic chain_enable_in_ch2, // Enable input, channel 2.
  output logic actuator_power_en, // Inductive supply to the actuator.
  output logic data_link_en, // Data exchange with the actuator.
  output logic safety_out_ch1, // Safety output, channel 1.
  output logic safety_out_ch2, // Safety output, channel 2.
  output logic guard_diag_out, // Non-safety diagnostic output.
  input wire logic [ADDR_W-1:0] avs_address, // Avalon byte address.
  input wire logic avs_read, // Avalon read request.
  input wire logic avs_write, // Avalon write request.
  input wire logic [31:0] avs_writedata, // Avalon write data.
  input wire logic [3:0] avs_byteenable, // Avalon byte enables.
  output logic [31:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait request.
  output logic irq // Level interrupt, active high.
);

  sosc_ctl_if ctl ();

  sosc_pulse_gen #(
    .PERIOD_CYC(TP_PERIOD_CYCLES),
    .WIDTH_CYC(TP_WIDTH_CYCLES)
  ) u_pulse (
    .clock(clock),
    .rst_n(rst_n),
    .ctl(ctl.pulse)
  );

  sosc_start_det #(
    .MIN_CYC(START_MIN_CYCLES),
    .MAX_CYC(START_MAX_CYCLES)
  ) u_start (
    .clock(clock),
    .rst_n(rst_n),
    .start_in(start_in),
    .ctl(ctl.det)
  );

  sosc_state_type state_r;
  sosc_state_type state_nxt;
  logic [CNT_W-1:0] phase_cnt_r;
  logic link_up_r;
  logic coding_ok;
  logic enables_ok;
  logic auto_mode_r;
  logic pattern_miss_r;
  logic force_manual_r;
  logic switch_on_ok;
  logic out1_r;
  logic out2_r;
  logic diag_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  logic bus_req;
  logic bus_done;
  logic en_drop;

  // Supply and data exchange follow the actuator range alone.
  assign actuator_power_en = actuator_in_range;
  assign data_link_en = actuator_in_range;

  // Coding is only believed once the link has been up for a cycle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      link_up_r <= 1'b0;
    else
      link_up_r <= actuator_in_range;
  end

  assign coding_ok = actuator_in_range & link_up_r & coding_valid;
  assign enables_ok = chain_enable_in_ch1 & chain_enable_in_ch2;

  // Start phase timer.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase_cnt_r <= '0;
    else if (state_r == ST_STARTUP)
      phase_cnt_r <= phase_cnt_r + CNT_W'(1);
  end

  // During the start phase the start input must mirror output one.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pattern_miss_r <= 1'b0;
    else if (state_r == ST_STARTUP && start_in != out1_r)
      pattern_miss_r <= 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      auto_mode_r <= 1'b0;
    else if (state_r == ST_STARTUP && state_nxt != ST_STARTUP)
      auto_mode_r <= ~pattern_miss_r & ~force_manual_r;
  end

  // In manual mode only a validated falling edge starts; autostart needs none.
  assign switch_on_ok = auto_mode_r | ctl.start_cmd;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STARTUP:
        if (phase_cnt_r >= START_PHASE_CYCLES - CNT_W'(1))
          state_nxt = ST_OPEN;
      ST_OPEN:
        if (coding_ok)
          state_nxt = ST_ARMED;
      ST_ARMED:
        if (!coding_ok)
          state_nxt = ST_OPEN;
        else if (enables_ok && switch_on_ok)
          state_nxt = ST_ACTIVE;
      ST_ACTIVE:
        if (!coding_ok)
          state_nxt = ST_OPEN;
        else if (!enables_ok)
          state_nxt = ST_ARMED;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= ST_STARTUP;
    else
      state_r <= state_nxt;
  end

  // Both channels are driven from the same decision; on they carry low test pulses,
  // off during the start phase they carry high test pulses for autostart detection.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end
    else
    begin
      out1_r <= (state_nxt == ST_ACTIVE) ? ~ctl.test_pulse :
                ((state_nxt == ST_STARTUP) & ctl.test_pulse);
      out2_r <= (state_nxt == ST_ACTIVE) ? ~ctl.test_pulse :
                ((state_nxt == ST_STARTUP) & ctl.test_pulse);
    end
  end

  // Diagnostic is a plain reflection of state and feeds nothing back.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      diag_r <= 1'b1;
    else
      diag_r <= (state_nxt != ST_ACTIVE);
  end

  assign safety_out_ch1 = out1_r;
  assign safety_out_ch2 = out2_r;
  assign guard_diag_out = diag_r;

  // Avalon slave: one wait cycle, then the answer.
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ack_r;
  assign avs_waitrequest = bus_req & ~ack_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & ~ack_r;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      force_manual_r <= CTRL_RESET[CTRL_FORCE_MANUAL];
    else if (bus_done && avs_write && avs_address == REG_CTRL && avs_byteenable[0])
      force_manual_r <= avs_writedata[CTRL_FORCE_MANUAL];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_r <= IRQ_MASK_RESET;
    else if (bus_done && avs_write && avs_address == REG_IRQ_MASK && avs_byteenable[0])
      irq_mask_r <= avs_writedata[IRQ_W-1:0];
  end

  assign en_drop = (state_r == ST_ACTIVE) & coding_ok & ~enables_ok;

  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_ON] = (state_r != ST_ACTIVE) && (state_nxt == ST_ACTIVE);
    irq_set[IRQ_OFF] = (state_r == ST_ACTIVE) && (state_nxt != ST_ACTIVE);
    // The mode is still open during the start phase, so no reject is reported there.
    irq_set[IRQ_START_REJ] = ctl.start_reject & ~auto_mode_r & (state_r != ST_STARTUP);
    irq_set[IRQ_EN_DROP] = en_drop;
  end

  // A read clears the status at the edge that captures its data, so no event is lost
  // between capture and completion; an event in the same cycle survives.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_r <= '0;
    else if (avs_read && !ack_r && avs_address == REG_IRQ_STATUS)
      irq_status_r <= irq_set;
    else
      irq_status_r <= irq_status_r | irq_set;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_status_r & irq_mask_r);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else if (avs_read && !ack_r)
    begin
      rdata_r <= '0;
      unique case (avs_address)
        REG_CTRL:
          rdata_r[CTRL_FORCE_MANUAL] <= force_manual_r;
        REG_STATUS:
        begin
          rdata_r[ST_STATE_LSB +: 2] <= state_r;
          rdata_r[ST_AUTO] <= auto_mode_r;
          rdata_r[ST_IN_RANGE] <= actuator_in_range;
          rdata_r[ST_CODING] <= coding_ok;
          rdata_r[ST_EN_CH1] <= chain_enable_in_ch1;
          rdata_r[ST_EN_CH2] <= chain_enable_in_ch2;
          rdata_r[ST_OUT_ON] <= (state_r == ST_ACTIVE);
        end
        REG_IRQ_STATUS:
          rdata_r[IRQ_W-1:0] <= irq_status_r;
        REG_IRQ_MASK:
          rdata_r[IRQ_W-1:0] <= irq_mask_r;
        default:
          rdata_r <= '0;
      endcase
    end
  end

  assign avs_readdata = rdata_r;

endmodule

//--- test/sosc_chk.sv
// Concurrent checks on the ports of the safety output switch control.
module sosc_chk
  import sosc_pkg::*;
#(
  parameter logic [CNT_W-1:0] START_PHASE_CYCLES = START_PHASE_CYC,
  parameter logic [CNT_W-1:0] TP_PERIOD_CYCLES = TP_PERIOD_CYC
)(
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic actuator_in_range, // Range input.
  input wire logic chain_enable_in_ch1, // Enable one.
  input wire logic chain_enable_in_ch2, // Enable two.
  input wire logic actuator_power_en, // Actuator supply.
  input wire logic data_link_en, // Actuator data.
  input wire logic safety_out_ch1, // Output one.
  input wire logic safety_out_ch2, // Output two.
  input wire logic guard_diag_out, // Diagnostic output.
  input wire logic avs_read, // Bus read.
  input wire logic avs_write, // Bus write.
  input wire logic avs_waitrequest // Bus wait.
);
  logic [CNT_W-1:0] cyc_r;
  logic [CNT_W-1:0] hi_r;
  logic done;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // The start phase plus a small margin must have passed before off means quiet.
  assign done = cyc_r > START_PHASE_CYCLES + 32'h2;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cyc_r <= '0;
    else if (!done)
      cyc_r <= cyc_r + 32'h1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hi_r <= '0;
    else if (safety_out_ch1)
      hi_r <= hi_r + 32'h1;
    else
      hi_r <= '0;
  end

  sequence s_off;
    !safety_out_ch1 && !safety_out_ch2 && guard_diag_out;
  endsequence

  AST_CH_PAIR: assert property (safety_out_ch1 == safety_out_ch2)
    else $error("Output channels differ.");
  AST_POWER: assert property (
    actuator_power_en == actuator_in_range && data_link_en == actuator_in_range)
    else $error("Actuator supply does not follow range.");
  AST_RESET_OFF: assert property (cyc_r < START_PHASE_CYCLES |-> guard_diag_out)
    else $error("Diagnostic low during start phase.");
  AST_DIAG_OFF: assert property (
    done && guard_diag_out |-> !safety_out_ch1 && !safety_out_ch2)
    else $error("Output high while diagnostic on.");
  AST_RANGE_OFF: assert property (done && !actuator_in_range |-> ##[1:2] s_off)
    else $error("Outputs not off out of range.");
  AST_DIAG_ON: assert property ($fell(actuator_in_range) |-> ##[1:2] guard_diag_out)
    else $error("Diagnostic not on after leaving.");
  AST_EN_DROP: assert property (
    done && !(chain_enable_in_ch1 && chain_enable_in_ch2) |-> ##[1:2] !safety_out_ch1)
    else $error("Output on without both enables.");
  AST_HIGH_RUN: assert property (hi_r <= TP_PERIOD_CYCLES)
    else $error("No test pulse while on.");
  AST_LOW_PULSE: assert property (
    !guard_diag_out && !safety_out_ch1 |-> ##[1:4] (safety_out_ch1 || guard_diag_out))
    else $error("Test pulse too long.");
  AST_START_PULSE: assert property (!done && $rose(safety_out_ch1) |-> ##[1:4] !safety_out_ch1)
    else $error("Start phase pulse too long.");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer late.");
endmodule

bind sosc_top sosc_chk #(
  .START_PHASE_CYCLES(START_PHASE_CYCLES),
  .TP_PERIOD_CYCLES(TP_PERIOD_CYCLES)
) sosc_chk_inst (
  .clock(clock),
  .rst_n(rst_n),
  .actuator_in_range(actuator_in_range),
  .chain_enable_in_ch1(chain_enable_in_ch1),
  .chain_enable_in_ch2(chain_enable_in_ch2),
  .actuator_power_en(actuator_power_en),
  .data_link_en(data_link_en),
  .safety_out_ch1(safety_out_ch1),
  .safety_out_ch2(safety_out_ch2),
  .guard_diag_out(guard_diag_out),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest)
);

//--- test/sosc_eval_model.sv
// Downstream evaluation device that rides through short output test pulses.
module sosc_eval_model #(
  parameter int FILT = 6
)(
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic ch1, // First safety output.
  input wire logic ch2, // Second safety output.
  output logic eval_on // Filtered output state.
);
  int low_r;

  // Only a low lasting FILT cycles counts as a switch-off.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      low_r <= FILT;
    else if (ch1 && ch2)
      low_r <= 0;
    else if (low_r < FILT)
      low_r <= low_r + 1;
  end

  assign eval_on = low_r < FILT;
endmodule

//--- test/tb_sosc_top.sv
// Self-checking bench of the safety output switch control.
module tb_sosc_top
  import sosc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [CNT_W-1:0] MIN = 32'ha;
  localparam logic [CNT_W-1:0] MAX = 32'hc8;
  localparam logic [CNT_W-1:0] PH = 32'h40;
  logic clock, rst_n, actuator_in_range, coding_valid, start_in, bridge, start_lvl;
  logic chain_enable_in_ch1, chain_enable_in_ch2, avs_read, avs_write, avs_waitrequest;
  logic actuator_power_en, data_link_en, safety_out_ch1, safety_out_ch2, guard_diag_out;
  logic irq, eval_on;
  logic [ADDR_W-1:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int n_fail, tests_run, n, k, seen;
  int lens [4];

  sosc_top #(.START_MIN_CYCLES(MIN), .START_MAX_CYCLES(MAX), .START_PHASE_CYCLES(PH),
    .TP_PERIOD_CYCLES(32'h20), .TP_WIDTH_CYCLES(32'h2)) sosc_top_inst (
    .clock(clock), .rst_n(rst_n), .actuator_in_range(actuator_in_range),
    .coding_valid(coding_valid), .start_in(start_in),
    .chain_enable_in_ch1(chain_enable_in_ch1), .chain_enable_in_ch2(chain_enable_in_ch2),
    .actuator_power_en(actuator_power_en), .data_link_en(data_link_en),
    .safety_out_ch1(safety_out_ch1), .safety_out_ch2(safety_out_ch2),
    .guard_diag_out(guard_diag_out), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

  sosc_eval_model sosc_eval_model_inst (.clock(clock), .rst_n(rst_n),
    .ch1(safety_out_ch1), .ch2(safety_out_ch2), .eval_on(eval_on));

  always #5 clock = ~clock;

  // Autostart wiring loops the first output back into the start input.
  assign start_in = bridge ? safety_out_ch1 : start_lvl;

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  task final_report;
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task cyc(input int c);
    repeat (c) @(posedge clock);
  endtask

  task wait_diag(input logic v);
    int i;
    for (i = 0; i < 400 && guard_diag_out !== v; i++)
      @(negedge clock);
    if (i == 400)
    begin
      n_fail++;
      final_report;
    end
  endtask

  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      n_fail++;
      final_report;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task do_reset(input logic b);
    rst_n <= 1'b0;
    bridge <= b;
    actuator_in_range <= 1'b0;
    cyc(6);
    rst_n <= 1'b1;
    cyc(PH + 32'h8);
  endtask

  task pulse(input int c);
    @(posedge clock);
    start_lvl <= 1'b1;
    cyc(c);
    start_lvl <= 1'b0;
  endtask

  function automatic logic [31:0] st_word(input logic [1:0] s, input logic a);
    st_word = 32'h0;
    st_word[1:0] = s;
    st_word[ST_AUTO] = a;
    st_word[ST_IN_RANGE] = actuator_in_range;
    st_word[ST_CODING] = actuator_in_range & coding_valid;
    st_word[ST_EN_CH1] = chain_enable_in_ch1;
    st_word[ST_EN_CH2] = chain_enable_in_ch2;
    st_word[ST_OUT_ON] = s == 2'h3;
  endfunction

  function automatic logic start_ok(input int c);
    start_ok = c >= MIN && c <= MAX;
  endfunction

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    coding_valid = 1'b0;
    start_lvl = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    n_fail = 0;
    tests_run = 0;
    seen = 0;
    // The first switch of a chain has its enables tied high.
    chain_enable_in_ch1 = 1'b1;
    chain_enable_in_ch2 = 1'b1;
    void'($urandom(32'ha1b89afb));
    do_reset(1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, st_word(ST_OPEN, 1'b1));
    @(posedge clock);
    actuator_in_range <= 1'b1;
    coding_valid <= 1'b1;
    wait_diag(1'b0);
    cyc(4);
    for (n = 0; n < 64; n++)
    begin
      @(negedge clock);
      check(eval_on, 1'b1);
      seen += (safety_out_ch1 === 1'b0);
    end
    check(seen > 0, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, st_word(ST_ACTIVE, 1'b1));
    @(posedge clock);
    if ($urandom % 2)
      chain_enable_in_ch1 <= 1'b0;
    else
      chain_enable_in_ch2 <= 1'b0;
    wait_diag(1'b1);
    check(safety_out_ch1, 1'b0);
    @(posedge clock);
    chain_enable_in_ch1 <= 1'b1;
    chain_enable_in_ch2 <= 1'b1;
    wait_diag(1'b0);
    @(posedge clock);
    actuator_in_range <= 1'b0;
    cyc(3);
    @(negedge clock);
    check(guard_diag_out, 1'b1);
    check(safety_out_ch1 | safety_out_ch2, 1'b0);
    check(irq, 1'b0);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    check(rd, 32'hb);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h0);
    do_reset(1'b0);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h4);
    @(posedge clock);
    actuator_in_range <= 1'b1;
    cyc(4);
    @(negedge clock);
    check(guard_diag_out, 1'b1);
    check(safety_out_ch1, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    check(rd, st_word(ST_ARMED, 1'b0));
    lens = '{MIN - 1, MAX + 1, MIN, MIN + $urandom % (MAX - MIN + 1)};
    for (k = 0; k < 4; k++)
    begin
      pulse(lens[k]);
      if (start_ok(lens[k]))
      begin
        wait_diag(1'b0);
        cyc(4);
        @(negedge clock);
        check(eval_on, 1'b1);
        @(posedge clock);
        actuator_in_range <= 1'b0;
        cyc(4);
        actuator_in_range <= 1'b1;
        cyc(4);
      end
      else
      begin
        cyc(4);
        @(negedge clock);
        check(guard_diag_out, 1'b1);
        check(irq, 1'b1);
        bus(1'b0, REG_IRQ_STATUS, 32'h0);
        check(rd & 32'h4, 32'h4);
        cyc(2);
        @(negedge clock);
        check(irq, 1'b0);
      end
    end
    final_report;
  end
endmodule
